/* hdl/ifd_defs.vh */
// Purpose: Constants for the instruction format decoder: register map, fields, timing, opcodes.
// Assumes: Included by hdl/ifd_decoder.v and by the testbench.
// Notes:   Definitions only.
`ifndef IFD_DEFS_VH
`define IFD_DEFS_VH

// Register byte offsets
`define IFD_OFS_INSTR       8'h00
`define IFD_OFS_CTRL        8'h04
`define IFD_OFS_STATUS      8'h08
`define IFD_OFS_FIELDA      8'h0C
`define IFD_OFS_FIELDB      8'h10
`define IFD_OFS_FIELDC      8'h14

// Reset values
`define IFD_INSTR_RST       14'h0000
`define IFD_CTRL_RST        3'h0

// Control register bits
`define IFD_CTRL_SKIP_TRUE  0
`define IFD_CTRL_PTR0_PROG  1
`define IFD_CTRL_PTR1_PROG  2

// Word geometry
`define IFD_WORD_W          14
`define IFD_FILE_W          7

// Format classes
`define IFD_CLS_BYTE        2'h0
`define IFD_CLS_BIT         2'h1
`define IFD_CLS_LIT         2'h2

// Timing: oscillator clocks per instruction cycle
`define IFD_CLK_PER_ICYC    4
`define IFD_QPH_LAST        2'h3
`define IFD_QPH_READ        2'h1
`define IFD_QPH_WRITE       2'h3

// Opcode patterns
`define IFD_OP3_CALL        3'h4
`define IFD_OP3_JUMP        3'h5
`define IFD_OP5_RELJ        5'h19
`define IFD_OP6_RETLIT      6'h34
`define IFD_OP6_DECSKIP     6'h0B
`define IFD_OP6_INCSKIP     6'h0F
`define IFD_OP7_PAGELD      7'h63
`define IFD_OP7_PTROFS      7'h62
`define IFD_OP9_BANKLD      9'h001
`define IFD_OP11_PTRINC0    11'h002
`define IFD_OP11_PTRINC1    11'h003
`define IFD_W_SUBRET        14'h0008
`define IFD_W_INTEXIT       14'h0009
`define IFD_W_ACCCALL       14'h000A
`define IFD_W_ACCRELJ       14'h000B

// Indirect access register file addresses
`define IFD_IND0_ADDR       7'h00
`define IFD_IND1_ADDR       7'h01

`endif

/* hdl/ifd_decoder.v */
// Purpose: Sorts 14-bit instruction words into format classes, extracts fields and
//          sequences instruction cycles with read-modify-write strobes for the datapath.
// Assumes: APB master in the mclk domain; inputs synchronous to mclk.
// Notes:   Software issues a word by writing the instruction register.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ifd_defs.vh"

// How it works
// (RQ1) Each instruction is one 14-bit word holding opcode and all operands.
// (RQ2) Words are sorted into byte-oriented, bit-oriented and literal/control classes.
// (RQ3) One instruction cycle per instruction, except the listed multi-cycle cases.
// (RQ4) Direct and accumulator subroutine invokes take two cycles.
// (RQ5) Subroutine exit, exit with literal and interrupt exit take two cycles.
// (RQ6) Jumps, and skips that change flow, take two cycles.
// (RQ7) Indirect access with pointer in program memory adds one cycle.
// (RQ8) One instruction cycle is four oscillator clocks.
// (RQ9) File operands are read, modified and stored; read happens even for pure writes.
// (RQ10) Destination bit 0 routes result to accumulator, 1 to the file register.
// (RQ11) File address is seven bits, 0x00 to 0x7F.
// (RQ12) Byte format: opcode 13..8, destination bit 7, file address 6..0.
// (RQ13) Bit format: opcode 13..10, bit position 9..7, file address 6..0.
// (RQ14) General literal format: opcode 13..8, 8-bit immediate 7..0.
// (RQ15) Direct invoke and absolute jump: opcode 13..11, 11-bit target 10..0.
// (RQ16) Page latch load: opcode 13..7, 7-bit immediate 6..0.
// (RQ17) Bank select load: 5-bit immediate in the low bits.
// (RQ18) Relative jump: opcode 13..9, 9-bit offset 8..0.
// (RQ19) Pointer offset: bit 6 selects pointer, bits 5..0 are the offset.
// (RQ20) Pointer increment: bit 2 selects pointer, bits 1..0 select the mode.
// (RQ21) Don't-care bits are ignored; either value decodes alike. Here don't-care file address bits still feed the indirect extra-cycle test.
// (RQ22) Second cycle of a flow change or taken skip is an idle cycle.
// (RQ23) A skip with false condition completes in one cycle.
module ifd_decoder (
	// Clock, reset, enable
	input  wire        mclk,
	input  wire        nrst,
	input  wire        ce,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Datapath strobes
	output reg         dp_read_q,
	output reg         dp_wr_file_q,
	output reg         dp_wr_acc_q,
	output reg  [6:0]  dp_addr_q,
	output reg         dp_idle_q,
	output reg         dp_icyc_q,
	output reg         dp_busy_q,
	output reg         dp_done_q
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_EXEC = 3'b010;
	localparam [2:0] ST_WAIT = 3'b100;

	// Cycle count of one instruction
	function [1:0] ifd_cycles;
		input flow;
		input ind;
		begin
			ifd_cycles = 2'h1 + {1'b0, flow} + {1'b0, ind}; // RQ3
		end
	endfunction

	// Indirect access register test
	function ifd_is_ind;
		input [6:0] addr;
		input       sel;
		begin
			ifd_is_ind = (addr == `IFD_IND0_ADDR) || (addr == `IFD_IND1_ADDR);
			ifd_is_ind = ifd_is_ind && sel;
		end
	endfunction

	// Field slices for the field readback; all but bit position and op7 also serve the issue decode
	function [5:0] ifd_op6;
		input [13:0] iw;
		begin
			ifd_op6 = iw[13:8]; // RQ12
		end
	endfunction

	function [6:0] ifd_file;
		input [13:0] iw;
		begin
			ifd_file = iw[6:0]; // RQ11
		end
	endfunction

	function [3:0] ifd_op4;
		input [13:0] iw;
		begin
			ifd_op4 = iw[13:10]; // RQ13
		end
	endfunction

	function [2:0] ifd_bitpos;
		input [13:0] iw;
		begin
			ifd_bitpos = iw[9:7]; // RQ13
		end
	endfunction

	function [2:0] ifd_op3;
		input [13:0] iw;
		begin
			ifd_op3 = iw[13:11]; // RQ15
		end
	endfunction

	function [4:0] ifd_op5;
		input [13:0] iw;
		begin
			ifd_op5 = iw[13:9]; // RQ18
		end
	endfunction

	function [6:0] ifd_op7;
		input [13:0] iw;
		begin
			ifd_op7 = iw[13:7]; // RQ16
		end
	endfunction

	// True at the phase end that closes the last instruction cycle of a word
	function ifd_last;
		input       ph_end;
		input [1:0] done;
		input [1:0] tot;
		begin
			ifd_last = ph_end && (done + 2'h1 == tot);
		end
	endfunction

	reg         rst_s1_n_q;
	reg         rst_n_q;
	reg  [13:0] instr_q;
	reg  [2:0]  ctrl_q;
	reg  [2:0]  state_q;
	reg  [1:0]  qph_q;
	reg  [1:0]  cyc_tot_q;
	reg  [1:0]  cyc_done_q;
	reg  [1:0]  cls_q;
	reg         file_op_q;
	reg         wr_file_q;
	reg         wr_acc_q;

	// Reset release through two flops
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_n_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_s1_n_q <= 1'b1;
			rst_n_q    <= rst_s1_n_q;
		end
	end

	// Field slicing of the pending word, byte, bit, literal, invoke/jump and relative jump layouts in parallel
	wire [13:0] w        = pwdata[13:0];  // RQ1
	wire [5:0]  op6      = ifd_op6(w);    // RQ12
	wire        dsel     = w[7];
	wire [6:0]  faddr    = ifd_file(w);   // RQ11
	wire [3:0]  op4      = ifd_op4(w);    // RQ13
	wire [2:0]  op3      = ifd_op3(w);    // RQ15
	wire [4:0]  op5      = ifd_op5(w);    // RQ18

	// Decode compares only the opcode bits, but don't-care file address bits still reach ind_extra through faddr
	wire is_ctl0   = (op6 == 6'h00) && !dsel; // RQ21
	wire is_byte11 = (op6 == 6'h35) || (op6 == 6'h36) || (op6 == 6'h37) ||
	                 (op6 == 6'h3B) || (op6 == 6'h3D);
	wire is_byte   = ((w[13:12] == 2'b00) && !is_ctl0) || is_byte11;
	wire is_bit    = (w[13:12] == 2'b01);
	wire [1:0] cls = is_byte ? `IFD_CLS_BYTE : (is_bit ? `IFD_CLS_BIT : `IFD_CLS_LIT); // RQ2

	wire is_call    = (op3 == `IFD_OP3_CALL);
	wire is_accall  = (w == `IFD_W_ACCCALL);
	wire is_subret  = (w == `IFD_W_SUBRET);
	wire is_intexit = (w == `IFD_W_INTEXIT);
	wire is_retlit  = (op6 == `IFD_OP6_RETLIT);
	wire is_jump    = (op3 == `IFD_OP3_JUMP);
	wire is_relj    = (op5 == `IFD_OP5_RELJ);
	wire is_accrelj = (w == `IFD_W_ACCRELJ);
	wire is_bitskip = is_bit && op4[1];
	wire is_byteskip = (op6 == `IFD_OP6_DECSKIP) || (op6 == `IFD_OP6_INCSKIP);
	wire is_skip    = is_bitskip || is_byteskip;

	wire flow_invoke = is_call || is_accall;                     // RQ4
	wire flow_exit   = is_subret || is_retlit || is_intexit;     // RQ5
	wire flow_jump   = is_jump || is_relj || is_accrelj;         // RQ6
	// A false skip adds no flow cycle and runs in one cycle unless its file address is a pointer held in program memory
	wire flow_skip   = is_skip && ctrl_q[`IFD_CTRL_SKIP_TRUE];   // RQ6 RQ23
	wire flow        = flow_invoke || flow_exit || flow_jump || flow_skip;

	wire file_op = is_byte || is_bit;
	wire ptr_prog = faddr[0] ? ctrl_q[`IFD_CTRL_PTR1_PROG] : ctrl_q[`IFD_CTRL_PTR0_PROG];
	wire ind_extra = file_op && ifd_is_ind(faddr, ptr_prog);     // RQ7

	// Bit skips only test; bit clear and set store to the file register
	wire wfile = (is_byte && dsel) || (is_bit && !op4[1]);       // RQ10
	wire wacc  = is_byte && !dsel;                               // RQ10

	// APB decode
	wire acc_ph  = psel && penable;
	wire done_ph = acc_ph && pready;
	wire wr_instr = done_ph && pwrite && (paddr == `IFD_OFS_INSTR) && (state_q == ST_IDLE);
	wire wr_ctrl  = done_ph && pwrite && (paddr == `IFD_OFS_CTRL);

	wire icyc_end = (qph_q == `IFD_QPH_LAST); // RQ8
	wire last_end = ifd_last(icyc_end, cyc_done_q, cyc_tot_q); // RQ3

	reg        map_ok;
	reg        err_d;
	reg [31:0] rd_d;

	always @* begin
		map_ok = 1'b1;
		err_d  = 1'b0;
		rd_d   = 32'h0000_0000;
		if (paddr == `IFD_OFS_INSTR) begin
			rd_d[13:0] = instr_q;
			err_d = pwrite && (state_q != ST_IDLE);
		end else if (paddr == `IFD_OFS_CTRL) begin
			rd_d[2:0] = ctrl_q;
		end else if (paddr == `IFD_OFS_STATUS) begin
			rd_d[0]   = (state_q != ST_IDLE);
			rd_d[2:1] = cls_q;
			rd_d[4:3] = cyc_tot_q;
			rd_d[6:5] = cyc_done_q;
			rd_d[7]   = (state_q == ST_WAIT);
			rd_d[9:8] = qph_q;
			err_d = pwrite;
		end else if (paddr == `IFD_OFS_FIELDA) begin
			rd_d[5:0]   = ifd_op6(instr_q);    // RQ12
			rd_d[6]     = instr_q[7];
			rd_d[13:7]  = ifd_file(instr_q);
			rd_d[17:14] = ifd_op4(instr_q);    // RQ13
			rd_d[20:18] = ifd_bitpos(instr_q);
			rd_d[23:21] = ifd_op3(instr_q);    // RQ15
			rd_d[28:24] = ifd_op5(instr_q);    // RQ18
			err_d = pwrite;
		end else if (paddr == `IFD_OFS_FIELDB) begin
			rd_d[7:0]   = instr_q[7:0];    // RQ14
			rd_d[18:8]  = instr_q[10:0];   // RQ15
			rd_d[27:19] = instr_q[8:0];    // RQ18
			err_d = pwrite;
		end else if (paddr == `IFD_OFS_FIELDC) begin
			rd_d[6:0]   = instr_q[6:0];    // RQ16
			rd_d[11:7]  = instr_q[4:0];    // RQ17
			rd_d[17:12] = instr_q[5:0];    // RQ19
			rd_d[18]    = instr_q[6];      // RQ19
			rd_d[19]    = instr_q[2];      // RQ20
			rd_d[21:20] = instr_q[1:0];    // RQ20
			rd_d[28:22] = ifd_op7(instr_q); // RQ16
			err_d = pwrite;
		end else begin
			map_ok = 1'b0;
		end
		if (!map_ok)
			err_d = 1'b1;
	end

	// APB slave: one wait state, answer registered
	always @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			if (acc_ph && !pready) begin
				pready  <= 1'b1;
				pslverr <= err_d;
				prdata  <= pwrite ? 32'h0000_0000 : rd_d;
			end else begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	// Control bits steer cycle counting of the next issued word
	always @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q)
			ctrl_q <= `IFD_CTRL_RST;
		else if (ce && wr_ctrl)
			ctrl_q <= pwdata[2:0];
	end

	// Issue: latch word and its decode, then run instruction cycles
	always @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			instr_q    <= `IFD_INSTR_RST;
			state_q    <= ST_IDLE;
			qph_q      <= 2'h0;
			cyc_tot_q  <= 2'h0;
			cyc_done_q <= 2'h0;
			cls_q      <= `IFD_CLS_BYTE;
			file_op_q  <= 1'b0;
			wr_file_q  <= 1'b0;
			wr_acc_q   <= 1'b0;
		end else if (ce) begin
			case (state_q)
				ST_IDLE: begin
					qph_q <= 2'h0;
					if (wr_instr) begin
						instr_q    <= w;
						cls_q      <= cls;
						file_op_q  <= file_op;
						wr_file_q  <= wfile;
						wr_acc_q   <= wacc;
						cyc_tot_q  <= ifd_cycles(flow, ind_extra); // RQ3 RQ7
						cyc_done_q <= 2'h0;
						state_q    <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					qph_q <= qph_q + 2'h1; // RQ8
					if (icyc_end) begin
						cyc_done_q <= cyc_done_q + 2'h1;
						if (cyc_tot_q == 2'h1)
							state_q <= ST_IDLE;   // RQ23
						else
							state_q <= ST_WAIT;   // RQ22
					end
				end
				ST_WAIT: begin
					qph_q <= qph_q + 2'h1;
					if (icyc_end) begin
						cyc_done_q <= cyc_done_q + 2'h1;
						if (last_end)
							state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Datapath strobes; all outputs registered
	always @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dp_read_q    <= 1'b0;
			dp_wr_file_q <= 1'b0;
			dp_wr_acc_q  <= 1'b0;
			dp_addr_q    <= 7'h00;
			dp_idle_q    <= 1'b0;
			dp_icyc_q    <= 1'b0;
			dp_busy_q    <= 1'b0;
			dp_done_q    <= 1'b0;
		end else if (ce) begin
			dp_addr_q <= ifd_file(instr_q); // RQ11
			// Read even when the instruction only writes, so peripheral side effects occur
			dp_read_q    <= (state_q == ST_EXEC) && file_op_q && (qph_q == `IFD_QPH_READ);  // RQ9
			dp_wr_file_q <= (state_q == ST_EXEC) && wr_file_q && (qph_q == `IFD_QPH_WRITE); // RQ9 RQ10
			dp_wr_acc_q  <= (state_q == ST_EXEC) && wr_acc_q && (qph_q == `IFD_QPH_WRITE);  // RQ10
			// Idle drops with the last phase end, so it never outlasts busy
			dp_idle_q    <= ((state_q == ST_WAIT) || ((state_q == ST_EXEC) && icyc_end)) &&
			                !last_end; // RQ22
			dp_icyc_q    <= ((state_q == ST_IDLE) && wr_instr) ||
			                ((state_q != ST_IDLE) && icyc_end && !last_end); // RQ8
			dp_busy_q    <= (state_q == ST_IDLE) ? wr_instr : !last_end;
			dp_done_q    <= (state_q != ST_IDLE) && last_end; // RQ3
		end
	end

endmodule // ifd_decoder
`default_nettype wire

/* testbench/ifd_props_properties.sv */
// Purpose: Concurrent checks on decoder cycle timing and APB answers.
// Assumes: ce held high, so no phase ever stalls.
// Notes:   Bound into every decoder instance.
`timescale 1ns/100ps
`default_nettype none
module ifd_props (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Datapath strobes
	input wire logic dp_read_q,
	input wire logic dp_wr_file_q,
	input wire logic dp_wr_acc_q,
	input wire logic dp_idle_q,
	input wire logic dp_icyc_q,
	input wire logic dp_busy_q,
	input wire logic dp_done_q
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	property p_done; dp_done_q |-> !dp_busy_q && $past(dp_busy_q); endproperty
	a_done: assert property (p_done) else $error("done without busy ending");
	property p_start; $rose(dp_busy_q) |-> dp_icyc_q && !dp_idle_q; endproperty
	a_start: assert property (p_start) else $error("word did not start a cycle");
	property p_gap; dp_icyc_q |=> !dp_icyc_q [*3]; endproperty
	a_gap: assert property (p_gap) else $error("cycle start too soon");
	property p_cyc4; dp_done_q |-> $past(dp_icyc_q, 4); endproperty
	a_cyc4: assert property (p_cyc4) else $error("done off the cycle grid");
	property p_rmw; dp_wr_file_q |-> $past(dp_read_q, 2); endproperty
	a_rmw: assert property (p_rmw) else $error("file store without read");
	property p_dest; dp_wr_acc_q |-> !dp_wr_file_q && $past(dp_read_q, 2); endproperty
	a_dest: assert property (p_dest) else $error("both destinations written");
	property p_idle; $rose(dp_idle_q) |-> (dp_idle_q && dp_busy_q) [*4]; endproperty
	a_idle: assert property (p_idle) else $error("idle cycle cut short");
	property p_idle_busy; dp_idle_q |-> dp_busy_q; endproperty
	a_idle_busy: assert property (p_idle_busy) else $error("idle cycle outside execution");
	property p_ready; pready |-> psel && penable && $past(psel && penable) ##1 !pready; endproperty
	a_ready: assert property (p_ready) else $error("pready outside access phase");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("pslverr without pready");
endmodule // ifd_props
bind ifd_decoder ifd_props ifd_props_inst (.mclk, .nrst, .psel, .penable, .pready, .pslverr, .dp_read_q,
	.dp_wr_file_q, .dp_wr_acc_q, .dp_idle_q, .dp_icyc_q, .dp_busy_q, .dp_done_q);
`default_nettype wire

/* testbench/ifd_dp_model.sv */
// Purpose: Execute datapath model that counts decoder strobes per word.
// Assumes: One word in flight; counts restart as busy rises.
// Notes:   No data is modelled; skip truth comes from the control register.
`timescale 1ns/100ps
`default_nettype none
module ifd_dp_model (
	// Clock
	input  wire logic       mclk,
	// Decoder strobes
	input  wire logic       dp_read_q,
	input  wire logic       dp_wr_file_q,
	input  wire logic       dp_wr_acc_q,
	input  wire logic       dp_idle_q,
	input  wire logic       dp_icyc_q,
	input  wire logic       dp_busy_q,
	// Counts for the last word
	output var  logic [3:0] n_icyc,
	output var  logic [3:0] n_rd,
	output var  logic [3:0] n_wf,
	output var  logic [3:0] n_wa,
	output var  logic [3:0] n_idle
);
	logic busy_q = 1'b0;
	wire logic st = dp_busy_q && !busy_q;
	always @(posedge mclk) begin
		busy_q <= dp_busy_q;
		n_icyc <= (st ? 4'h0 : n_icyc) + {3'h0, dp_icyc_q};
		n_rd <= (st ? 4'h0 : n_rd) + {3'h0, dp_read_q};
		n_wf <= (st ? 4'h0 : n_wf) + {3'h0, dp_wr_file_q};
		n_wa <= (st ? 4'h0 : n_wa) + {3'h0, dp_wr_acc_q};
		n_idle <= (st ? 4'h0 : n_idle) + {3'h0, dp_idle_q};
	end
endmodule // ifd_dp_model
`default_nettype wire

/* testbench/ifd_decoder_tb.sv */
// Purpose: Self-checking bench for the instruction format decoder over APB.
// Assumes: ce held high; skip truth and pointer location set via the control register.
// Notes:   Cycle counts are checked on the datapath model and on the status register total.
`timescale 1ns/100ps
`default_nettype none
`include "ifd_defs.vh"
module ifd_decoder_tb;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, dp_read_q, dp_wr_file_q, dp_wr_acc_q, dp_idle_q, dp_icyc_q, dp_busy_q, dp_done_q;
	logic [6:0]  dp_addr_q;
	logic [3:0]  n_icyc, n_rd, n_wf, n_wa, n_idle;
	int          err_total = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	logic [13:0] two [5] = '{14'h000A, 14'h0008, 14'h0009, 14'h000B, 14'h2923};
	always #20 mclk = ~mclk;
	ifd_decoder ifd_decoder_inst (.mclk, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .dp_read_q, .dp_wr_file_q, .dp_wr_acc_q, .dp_addr_q, .dp_idle_q, .dp_icyc_q, .dp_busy_q, .dp_done_q);
	ifd_dp_model ifd_dp_model_inst (.mclk, .dp_read_q, .dp_wr_file_q, .dp_wr_acc_q, .dp_idle_q, .dp_icyc_q,
		.dp_busy_q, .n_icyc, .n_rd, .n_wf, .n_wa, .n_idle);
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask
	// An idle edge after each transfer keeps psel from being assigned twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int t;
		t = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		chk("pready", 1, pready);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk("write pslverr", xe, e);
	endtask
	task automatic fld(input logic [7:0] a, input int lsb, input int w, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk("read pslverr", 0, e);
		chk("field", x, (r >> lsb) & ((32'h1 << w) - 1));
	endtask
	task automatic wait_idle;
		int t;
		t = 0;
		while (dp_busy_q !== 1'b0 && t < 40) begin
			@(posedge mclk);
			t++;
		end
	endtask
	task automatic run(input logic [13:0] w, input logic [2:0] c, input int n, input logic [1:0] cl, input logic wf,
		input logic wa);
		wr(`IFD_OFS_CTRL, {29'h0, c}, 1'b0);
		wr(`IFD_OFS_INSTR, {18'h0, w}, 1'b0);
		fld(`IFD_OFS_STATUS, 0, 5, {n[1:0], cl, 1'b1});
		wait_idle();
		#1;
		chk("cycles", n, n_icyc);
		chk("busy end", 0, dp_busy_q);
		chk("idle clocks", 4 * (n - 1), n_idle);
		chk("reads", cl != `IFD_CLS_LIT, n_rd);
		chk("file store", wf, n_wf);
		chk("acc store", wa, n_wa);
		@(posedge mclk);
		$display("test %h done", w);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		logic [31:0] r;
		logic e;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		fld(`IFD_OFS_INSTR, 0, 32, 32'h0);
		fld(`IFD_OFS_CTRL, 0, 32, 32'h0);
		fld(`IFD_OFS_STATUS, 0, 32, 32'h0);
		apb(1'b0, 8'h18, 32'h0, r, e);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, r);
		wr(`IFD_OFS_FIELDA, 32'hFFFFFFFF, 1'b1);
		$display("test reset values done");
		run(14'h07D5, 3'h0, 1, `IFD_CLS_BYTE, 1'b1, 1'b0);
		fld(`IFD_OFS_FIELDA, 0, 14, 32'h2AC7);
		run(14'h087F, 3'h0, 1, `IFD_CLS_BYTE, 1'b0, 1'b1);
		chk("file address", 7'h7F, dp_addr_q);
		run(14'h0100, 3'h0, 1, `IFD_CLS_BYTE, 1'b0, 1'b1);
		run(14'h0103, 3'h0, 1, `IFD_CLS_BYTE, 1'b0, 1'b1);
		run(14'h1792, 3'h0, 1, `IFD_CLS_BIT, 1'b1, 1'b0);
		fld(`IFD_OFS_FIELDA, 14, 7, 32'h75);
		run(14'h1D20, 3'h1, 2, `IFD_CLS_BIT, 1'b0, 1'b0);
		run(14'h1920, 3'h1, 2, `IFD_CLS_BIT, 1'b0, 1'b0);
		run(14'h1D20, 3'h0, 1, `IFD_CLS_BIT, 1'b0, 1'b0);
		run(14'h0B90, 3'h1, 2, `IFD_CLS_BYTE, 1'b1, 1'b0);
		run(14'h0F90, 3'h1, 2, `IFD_CLS_BYTE, 1'b1, 1'b0);
		run(14'h0B80, 3'h3, 3, `IFD_CLS_BYTE, 1'b1, 1'b0);
		run(14'h0780, 3'h2, 2, `IFD_CLS_BYTE, 1'b1, 1'b0);
		run(14'h0781, 3'h2, 1, `IFD_CLS_BYTE, 1'b1, 1'b0);
		run(14'h0781, 3'h4, 2, `IFD_CLS_BYTE, 1'b1, 1'b0);
		foreach (two[i]) run(two[i], 3'h0, 2, `IFD_CLS_LIT, 1'b0, 1'b0);
		run(14'h27FF, 3'h0, 2, `IFD_CLS_LIT, 1'b0, 1'b0);
		fld(`IFD_OFS_FIELDA, 21, 3, 32'h4);
		fld(`IFD_OFS_FIELDB, 8, 11, 32'h7FF);
		run(14'h33AB, 3'h0, 2, `IFD_CLS_LIT, 1'b0, 1'b0);
		fld(`IFD_OFS_FIELDA, 24, 5, 32'h19);
		fld(`IFD_OFS_FIELDB, 19, 9, 32'h1AB);
		run(14'h34A5, 3'h0, 2, `IFD_CLS_LIT, 1'b0, 1'b0);
		fld(`IFD_OFS_FIELDB, 0, 8, 32'hA5);
		run(14'h31DA, 3'h0, 1, `IFD_CLS_LIT, 1'b0, 1'b0);
		fld(`IFD_OFS_FIELDC, 0, 7, 32'h5A);
		fld(`IFD_OFS_FIELDC, 22, 7, 32'h63);
		run(14'h003F, 3'h0, 1, `IFD_CLS_LIT, 1'b0, 1'b0);
		fld(`IFD_OFS_FIELDC, 7, 5, 32'h1F);
		run(14'h316A, 3'h0, 1, `IFD_CLS_LIT, 1'b0, 1'b0);
		fld(`IFD_OFS_FIELDC, 12, 7, 32'h6A);
		run(14'h0017, 3'h0, 1, `IFD_CLS_LIT, 1'b0, 1'b0);
		fld(`IFD_OFS_FIELDC, 19, 3, 32'h7);
		fld(`IFD_OFS_INSTR, 0, 32, 32'h0017);
		wr(`IFD_OFS_INSTR, 32'h2923, 1'b0);
		wr(`IFD_OFS_INSTR, 32'h07D5, 1'b1);
		wait_idle();
		fld(`IFD_OFS_INSTR, 0, 32, 32'h2923);
		$display("test refusal done");
		print_verdict();
	end
endmodule // ifd_decoder_tb
`default_nettype wire
